// File: rnf_filter_assertions.sv
// Concurrent checks on the filter ports
`timescale 1ns/1ps
module rnf_chk (
   // Clock and resets
   input logic sys_clk,
   input logic rst,
   input logic power_on_rst,
   // Register bus
   input logic s_axi_awvalid,
   input logic s_axi_awready,
   input logic s_axi_wvalid,
   input logic s_axi_wready,
   input logic [1:0] s_axi_bresp,
   input logic s_axi_bvalid,
   input logic s_axi_bready,
   input logic s_axi_arvalid,
   input logic s_axi_arready,
   input logic [31:0] s_axi_rdata,
   input logic [1:0] s_axi_rresp,
   input logic s_axi_rvalid,
   input logic s_axi_rready,
   // Request path
   input logic [9:0] local_bus_id,
   input logic req_valid,
   input rnf_pkg::rnf_req_type req,
   input logic dec_valid,
   input rnf_pkg::rnf_dec_type dec
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst || power_on_rst);
   sequence s_wr_taken;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence s_ar_taken;
      s_axi_arvalid && s_axi_arready;
   endsequence
   property p_wr_answer;
      s_wr_taken |-> ##[1:3] s_axi_bvalid;
   endproperty
   a_wr_answer: assert property (p_wr_answer) else $error("write not answered");
   property p_rd_answer;
      s_ar_taken |-> ##[1:2] s_axi_rvalid;
   endproperty
   a_rd_answer: assert property (p_rd_answer) else $error("read not answered");
   property p_b_hold;
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
   endproperty
   a_b_hold: assert property (p_b_hold) else $error("write response dropped");
   property p_r_hold;
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
   endproperty
   a_r_hold: assert property (p_r_hold) else $error("read data dropped");
   property p_unmapped;
      s_axi_rvalid && s_axi_rresp == rnf_pkg::RESP_SLVERR |-> s_axi_rdata == 32'h0;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
   property p_dec_next;
      req_valid |=> dec_valid;
   endproperty
   a_dec_next: assert property (p_dec_next) else $error("no decision");
   property p_dec_cause;
      dec_valid |-> $past(req_valid);
   endproperty
   a_dec_cause: assert property (p_dec_cause) else $error("decision without request");
   property p_route;
      dec_valid |-> dec.accept == (dec.to_phys || dec.to_async) && !(dec.to_phys && dec.to_async);
   endproperty
   a_route: assert property (p_route) else $error("bad routing");
   property p_phys_kind;
      dec_valid && dec.to_phys |-> $past(req.is_phys);
   endproperty
   a_phys_kind: assert property (p_phys_kind) else $error("async sent to physical");
   property p_node_top;
      req_valid && req.node_id == 6'h3f && (req.bus_id == 10'h3ff || req.bus_id == local_bus_id)
         |=> !dec.accept;
   endproperty
   a_node_top: assert property (p_node_top) else $error("node 63 accepted");
endmodule
bind rnf_filter_top rnf_chk chk_u (.sys_clk, .rst, .power_on_rst, .s_axi_awvalid, .s_axi_awready,
   .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
   .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .local_bus_id,
   .req_valid, .req, .dec_valid, .dec);

// File: rnf_filter_top.sv
// Receive request node filter: AXI4-Lite register bank and request decision
`timescale 1ns/1ps
module rnf_filter_top (
   // Clock and resets
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic power_on_rst,
   // AXI4-Lite write address
   input wire logic [11:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   // AXI4-Lite write data
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // AXI4-Lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read address
   input wire logic [11:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   // AXI4-Lite read data
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Inbound request from the link
   input wire logic [9:0] local_bus_id,
   input wire logic req_valid,
   input wire rnf_pkg::rnf_req_type req,
   // Filter decision
   output logic dec_valid,
   output rnf_pkg::rnf_dec_type dec
);
   // Address decode shared by the read and write paths
   function automatic rnf_pkg::rnf_addr_type decode(input logic [11:0] addr);
      rnf_pkg::rnf_addr_type d;
      d = '0;
      d.hit = 1'b1;
      if (addr == rnf_pkg::ADDR_ASYNC_HIGH_SET) begin
         d.slot = rnf_pkg::FILT_ASYNC_HIGH;
      end else if (addr == rnf_pkg::ADDR_ASYNC_HIGH_CLEAR) begin
         d.slot = rnf_pkg::FILT_ASYNC_HIGH;
         d.is_clear = 1'b1;
      end else if (addr == rnf_pkg::ADDR_ASYNC_LOW_SET) begin
         d.slot = rnf_pkg::FILT_ASYNC_LOW;
      end else if (addr == rnf_pkg::ADDR_ASYNC_LOW_CLEAR) begin
         d.slot = rnf_pkg::FILT_ASYNC_LOW;
         d.is_clear = 1'b1;
      end else if (addr == rnf_pkg::ADDR_PHYS_HIGH_SET) begin
         d.slot = rnf_pkg::FILT_PHYS_HIGH;
      end else if (addr == rnf_pkg::ADDR_PHYS_HIGH_CLEAR) begin
         d.slot = rnf_pkg::FILT_PHYS_HIGH;
         d.is_clear = 1'b1;
      end else if (addr == rnf_pkg::ADDR_PHYS_LOW_SET) begin
         d.slot = rnf_pkg::FILT_PHYS_LOW;
      end else if (addr == rnf_pkg::ADDR_PHYS_LOW_CLEAR) begin
         d.slot = rnf_pkg::FILT_PHYS_LOW;
         d.is_clear = 1'b1;
      end else begin
         d.hit = 1'b0;
      end
      return d;
   endfunction

   // Expands byte strobes into a bit mask
   function automatic logic [31:0] strobe_mask(input logic [3:0] strb);
      logic [31:0] m;
      m = '0;
      for (int i = 0; i < 4; i++) begin
         m[i*8 +: 8] = {8{strb[i]}};
      end
      return m;
   endfunction

   // Write channel state
   logic aw_held;
   logic [11:0] aw_addr;
   logic w_held;
   logic [31:0] w_data;
   logic [3:0] w_strb;
   logic next_aw_held;
   logic [11:0] next_aw_addr;
   logic next_w_held;
   logic [31:0] next_w_data;
   logic [3:0] next_w_strb;
   logic next_awready;
   logic next_wready;
   logic next_bvalid;
   logic [1:0] next_bresp;
   logic wr_fire;
   rnf_pkg::rnf_addr_type wr_dec;
   logic [31:0] wr_mask;

   // Read channel state
   logic next_arready;
   logic next_rvalid;
   logic [31:0] next_rdata;
   logic [1:0] next_rresp;
   rnf_pkg::rnf_addr_type rd_dec;

   // Filter storage
   logic [31:0] filt_val [rnf_pkg::FILT_COUNT];

   // Decision path
   logic next_dec_valid;
   rnf_pkg::rnf_dec_type next_dec;
   logic async_node_accept;
   logic phys_node_route;
   logic src_local;

   always_comb begin
      next_aw_held = aw_held;
      next_aw_addr = aw_addr;
      next_w_held = w_held;
      next_w_data = w_data;
      next_w_strb = w_strb;
      next_bvalid = s_axi_bvalid;
      next_bresp = s_axi_bresp;
      if (s_axi_awvalid && s_axi_awready) begin
         next_aw_held = 1'b1;
         next_aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         next_w_held = 1'b1;
         next_w_data = s_axi_wdata;
         next_w_strb = s_axi_wstrb;
      end
      if (s_axi_bvalid && s_axi_bready) begin
         next_bvalid = 1'b0;
      end
      if (wr_fire) begin
         next_aw_held = 1'b0;
         next_w_held = 1'b0;
         next_bvalid = 1'b1;
         next_bresp = wr_dec.hit ? rnf_pkg::RESP_OKAY : rnf_pkg::RESP_SLVERR;
      end
      // Address and data are taken in either order, one write at a time
      next_awready = !next_aw_held && !next_bvalid;
      next_wready = !next_w_held && !next_bvalid;
   end

   assign wr_fire = aw_held && w_held && !s_axi_bvalid;
   assign wr_dec = decode({aw_addr[11:2], 2'h0});
   assign wr_mask = w_data & strobe_mask(w_strb);

   always_ff @(posedge sys_clk) begin
      if (rst || power_on_rst) begin
         aw_held <= 1'b0;
         aw_addr <= '0;
         w_held <= 1'b0;
         w_data <= '0;
         w_strb <= '0;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= rnf_pkg::RESP_OKAY;
      end else begin
         aw_held <= next_aw_held;
         aw_addr <= next_aw_addr;
         w_held <= next_w_held;
         w_data <= next_w_data;
         w_strb <= next_w_strb;
         s_axi_awready <= next_awready;
         s_axi_wready <= next_wready;
         s_axi_bvalid <= next_bvalid;
         s_axi_bresp <= next_bresp;
      end
   end

   // Filter registers, one per slot
   genvar gi;
   generate
      for (gi = 0; gi < rnf_pkg::FILT_COUNT; gi++) begin : g_filt
         localparam logic [31:0] KEEP = (gi == int'(rnf_pkg::FILT_PHYS_HIGH)) ?
            rnf_pkg::PHYS_HIGH_KEEP_MASK : rnf_pkg::NO_KEEP_MASK;
         logic sel;
         assign sel = wr_fire && wr_dec.hit && (wr_dec.slot == 2'(gi));
         // set and clear ports; zero reset, except that a host bus reset keeps bit 31 of the physical high slot
         rnf_set_clear_reg #(
            .WIDTH(32),
            .KEEP_MASK(KEEP)
         ) u_reg (
            .sys_clk(sys_clk),
            .rst(rst),
            .power_on_rst(power_on_rst),
            .set_en(sel && !wr_dec.is_clear),
            .clear_en(sel && wr_dec.is_clear),
            .wmask(wr_mask),
            .value(filt_val[gi])
         );
      end
   endgenerate

   always_comb begin
      next_rvalid = s_axi_rvalid;
      next_rdata = s_axi_rdata;
      next_rresp = s_axi_rresp;
      if (s_axi_rvalid && s_axi_rready) begin
         next_rvalid = 1'b0;
      end
      if (s_axi_arvalid && s_axi_arready) begin
         next_rvalid = 1'b1;
         if (rd_dec.hit) begin
            next_rdata = filt_val[rd_dec.slot];
            next_rresp = rnf_pkg::RESP_OKAY;
         end else begin
            next_rdata = rnf_pkg::READ_UNMAPPED;
            next_rresp = rnf_pkg::RESP_SLVERR;
         end
      end
      next_arready = !next_rvalid;
   end

   assign rd_dec = decode({s_axi_araddr[11:2], 2'h0});

   always_ff @(posedge sys_clk) begin
      if (rst || power_on_rst) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= '0;
         s_axi_rresp <= rnf_pkg::RESP_OKAY;
      end else begin
         s_axi_arready <= next_arready;
         s_axi_rvalid <= next_rvalid;
         s_axi_rdata <= next_rdata;
         s_axi_rresp <= next_rresp;
      end
   end

   rnf_node_lookup u_async_lookup (
      .map_low(filt_val[rnf_pkg::FILT_ASYNC_LOW]),
      .map_high(filt_val[rnf_pkg::FILT_ASYNC_HIGH]),
      .node_id(req.node_id),
      .hit(async_node_accept)
   );

   rnf_node_lookup u_phys_lookup (
      .map_low(filt_val[rnf_pkg::FILT_PHYS_LOW]),
      .map_high(filt_val[rnf_pkg::FILT_PHYS_HIGH]),
      .node_id(req.node_id),
      .hit(phys_node_route)
   );

   // local when bus matches or is the local alias
   assign src_local = (req.bus_id == rnf_pkg::LOCAL_BUS_ALIAS) ||
      (req.bus_id == local_bus_id);

   always_comb begin
      next_dec_valid = req_valid;
      next_dec = '0;
      if (req_valid) begin
         if (src_local) begin
            next_dec.accept = async_node_accept;
            // clear physical bit falls back to async context
            next_dec.to_phys = async_node_accept && req.is_phys && phys_node_route;
            next_dec.to_async = async_node_accept && !(req.is_phys && phys_node_route);
         end else begin
            // nonlocal gated by upper physical bit 31
            if (filt_val[rnf_pkg::FILT_PHYS_HIGH][rnf_pkg::REMOTE_BUS_BIT]) begin
               // Remote packets of both kinds pass once bit 31 is set
               next_dec.accept = 1'b1;
               if (req.is_phys) begin
                  next_dec.to_phys = 1'b1;
               end else begin
                  // Remote async requests use the async context
                  next_dec.to_async = 1'b1;
               end
            end
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst || power_on_rst) begin
         dec_valid <= 1'b0;
         dec <= '0;
      end else begin
         dec_valid <= next_dec_valid;
         dec <= next_dec;
      end
   end
endmodule

// File: rnf_filter_top_tb.sv
// Self-checking bench for the receive request node filter
`timescale 1ns/1ps
module rnf_filter_top_tb;
   logic sys_clk, rst, power_on_rst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic req_valid, dec_valid, en, b_prev;
   logic [11:0] s_axi_awaddr, s_axi_araddr, w_addr;
   logic [31:0] s_axi_wdata, s_axi_rdata, w_mask;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [9:0] local_bus_id;
   rnf_pkg::rnf_req_type req;
   rnf_pkg::rnf_dec_type dec;
   logic [31:0] sh [4];
   logic [33:0] rq [$];
   logic [1:0] bq [$];
   logic [2:0] dq [$];
   int failures, samples_checked, seed, i, k;
   rnf_filter_top dut_u (.sys_clk, .rst, .power_on_rst, .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
      .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .local_bus_id, .req_valid, .req, .dec_valid,
      .dec);
   rnf_node_model node_u (.sys_clk, .en, .local_bus_id, .req_valid, .req);
   initial begin
      sys_clk = 1'b0;
      forever #12.5 sys_clk = ~sys_clk;
   end
   task automatic check(input logic [33:0] seen, input logic [33:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         failures++;
         $display("Error at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic summarize;
      $display("Checked %0d, mismatches %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   function automatic logic [2:0] exp_dec(input rnf_pkg::rnf_req_type r);
      logic a, p;
      a = 1'b0;
      p = 1'b0;
      if (r.bus_id == 10'h3ff || r.bus_id == local_bus_id) begin
         if (r.node_id < 6'd32) begin
            a = sh[1][r.node_id[4:0]];
            p = sh[3][r.node_id[4:0]];
         end else if (r.node_id != 6'h3f) begin
            a = sh[0][r.node_id[4:0]];
            p = sh[2][r.node_id[4:0]];
         end
         return {a, a && r.is_phys && p, a && !(r.is_phys && p)};
      end
      if (!sh[2][31]) return 3'h0;
      if (r.is_phys) return 3'h6;
      return 3'h5;
   endfunction
   always @(posedge sys_clk) begin
      if (power_on_rst) begin
         sh = '{default: 32'h0};
      end else if (rst) begin
         sh = '{32'h0, 32'h0, sh[2] & 32'h8000_0000, 32'h0};
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            w_addr = s_axi_awaddr;
            bq.push_back(w_addr[11:5] == 7'h08 ? rnf_pkg::RESP_OKAY : rnf_pkg::RESP_SLVERR);
         end
         if (s_axi_wvalid && s_axi_wready) begin
            for (k = 0; k < 4; k++) w_mask[8*k+:8] = s_axi_wstrb[k] ? s_axi_wdata[8*k+:8] : 8'h0;
         end
         if (s_axi_bvalid && !b_prev && w_addr[11:5] == 7'h08) begin
            if (w_addr[2]) sh[w_addr[4:3]] = sh[w_addr[4:3]] & ~w_mask;
            else sh[w_addr[4:3]] = sh[w_addr[4:3]] | w_mask;
         end
         if (s_axi_arvalid && s_axi_arready) begin
            if (s_axi_araddr[11:5] == 7'h08) rq.push_back({2'h0, sh[s_axi_araddr[4:3]]});
            else rq.push_back({rnf_pkg::RESP_SLVERR, 32'h0});
         end
         if (req_valid) dq.push_back(exp_dec(req));
         if (dec_valid) check(34'(dec), 34'(dq.pop_front()));
         if (s_axi_bvalid && s_axi_bready) check(34'(s_axi_bresp), 34'(bq.pop_front()));
         if (s_axi_rvalid && s_axi_rready)
            check({s_axi_rresp, s_axi_rdata}, rq.pop_front());
      end
      b_prev <= s_axi_bvalid;
   end
   task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
      int n;
      logic done;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= s;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      done = 1'b0;
      for (n = 0; n < 40 && !done; n++) begin
         @(posedge sys_clk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
         done = s_axi_bvalid;
      end
      if (!done) begin
         failures++;
         summarize();
      end
   endtask
   task automatic rd(input logic [11:0] a);
      int n;
      logic done;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      done = 1'b0;
      for (n = 0; n < 40 && !done; n++) begin
         @(posedge sys_clk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
         done = s_axi_rvalid;
      end
      if (!done) begin
         failures++;
         summarize();
      end
   endtask
   task automatic pulse(input logic full);
      en <= 1'b0;
      repeat (3) @(posedge sys_clk);
      rst <= 1'b1;
      power_on_rst <= full;
      repeat (2) @(posedge sys_clk);
      rst <= 1'b0;
      power_on_rst <= 1'b0;
      @(posedge sys_clk);
   endtask
   initial begin
      {failures, samples_checked, seed} = {32'd0, 32'd0, 32'd91382};
      {rst, power_on_rst, s_axi_bready, s_axi_rready, en} = 5'b11110;
      {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, b_prev} = 4'h0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = 60'h0;
      local_bus_id = 10'h2a5;
      repeat (5) @(posedge sys_clk);
      rst <= 1'b0;
      power_on_rst <= 1'b0;
      for (i = 0; i < 8; i++) rd(12'h100 + 12'(4 * i));
      rd(12'h200);
      wr(12'h204, 32'hffff_ffff, 4'hf);
      $display("Test reset values done");
      en <= 1'b1;
      for (i = 0; i < 64; i++) begin
         wr(12'h100 + 12'(4 * ($random(seed) & 7)), $random(seed), 4'($random(seed)));
         rd(12'h100 + 12'(4 * ($random(seed) & 7)));
      end
      $display("Test random filters done");
      for (i = 0; i < 8; i += 2) wr(12'h100 + 12'(4 * i), 32'hffff_ffff, 4'hf);
      pulse(1'b0);
      for (i = 0; i < 8; i++) rd(12'h100 + 12'(4 * i));
      // Other bus number so that local and remote sources move
      local_bus_id <= 10'($random(seed));
      en <= 1'b1;
      repeat (200) @(posedge sys_clk);
      $display("Test host reset done");
      pulse(1'b1);
      rd(12'h110);
      en <= 1'b1;
      repeat (100) @(posedge sys_clk);
      en <= 1'b0;
      repeat (5) @(posedge sys_clk);
      $display("Test full reset done");
      summarize();
   end
endmodule

// File: rnf_node_lookup.sv
// Picks the filter bit that covers one local node from a low/high pair
`timescale 1ns/1ps
module rnf_node_lookup (
   // Bitmaps
   input wire logic [31:0] map_low,
   input wire logic [31:0] map_high,
   // Source node
   input wire logic [5:0] node_id,
   output logic hit
);
   always_comb begin
      if (!node_id[5]) begin
         hit = map_low[node_id[4:0]];
      end else if (node_id[4:0] == 5'h1f) begin
         // Broadcast node has no filter bit
         hit = 1'b0;
      end else begin
         hit = map_high[node_id[4:0]];
      end
   end
endmodule

// File: rnf_node_model.sv
// Remote nodes issuing random inbound requests
`timescale 1ns/1ps
module rnf_node_model (
   // Clock and control
   input logic sys_clk,
   input logic en,
   input logic [9:0] local_bus_id,
   // Request to the filter
   output logic req_valid,
   output rnf_pkg::rnf_req_type req
);
   int seed = 91382;
   logic [1:0] pick;
   rnf_pkg::rnf_req_type nr;
   initial req_valid = 1'b0;
   initial req = '0;
   always @(posedge sys_clk) begin
      nr = 17'($random(seed));
      pick = 2'($random(seed));
      if (pick == 2'h0) nr.bus_id = 10'h3ff;
      if (pick == 2'h1) nr.bus_id = local_bus_id;
      req_valid <= en && (pick != 2'h3 || nr.is_phys);
      // While en is low the lines flip between the last request and its inverse every cycle
      req <= en ? nr : ~req;
   end
endmodule

// File: rnf_pkg.sv
// Constants and types for the receive request node filter
package rnf_pkg;
   // Byte addresses of the set and clear ports
   localparam logic [11:0] ADDR_ASYNC_HIGH_SET = 12'h100;
   localparam logic [11:0] ADDR_ASYNC_HIGH_CLEAR = 12'h104;
   localparam logic [11:0] ADDR_ASYNC_LOW_SET = 12'h108;
   localparam logic [11:0] ADDR_ASYNC_LOW_CLEAR = 12'h10c;
   localparam logic [11:0] ADDR_PHYS_HIGH_SET = 12'h110;
   localparam logic [11:0] ADDR_PHYS_HIGH_CLEAR = 12'h114;
   localparam logic [11:0] ADDR_PHYS_LOW_SET = 12'h118;
   localparam logic [11:0] ADDR_PHYS_LOW_CLEAR = 12'h11c;

   // Filter slots
   localparam logic [1:0] FILT_ASYNC_HIGH = 2'h0;
   localparam logic [1:0] FILT_ASYNC_LOW = 2'h1;
   localparam logic [1:0] FILT_PHYS_HIGH = 2'h2;
   localparam logic [1:0] FILT_PHYS_LOW = 2'h3;
   localparam int FILT_COUNT = 4;

   localparam logic [31:0] FILTER_RESET = 32'h0000_0000;
   localparam int REMOTE_BUS_BIT = 31;
   // Bits that a host bus reset leaves alone
   localparam logic [31:0] PHYS_HIGH_KEEP_MASK = 32'h8000_0000;
   localparam logic [31:0] NO_KEEP_MASK = 32'h0000_0000;
   localparam logic [9:0] LOCAL_BUS_ALIAS = 10'h3ff;

   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   localparam logic [31:0] READ_UNMAPPED = 32'h0000_0000;

   typedef struct packed {
      logic is_phys;
      logic [9:0] bus_id;
      logic [5:0] node_id;
   } rnf_req_type;

   typedef struct packed {
      logic accept;
      logic to_phys;
      logic to_async;
   } rnf_dec_type;

   typedef struct packed {
      logic hit;
      logic [1:0] slot;
      logic is_clear;
   } rnf_addr_type;
endpackage

// File: rnf_set_clear_reg.sv
// One filter register with write-one-to-set and write-one-to-clear ports
`timescale 1ns/1ps
module rnf_set_clear_reg #(
   parameter int WIDTH = 32,
   parameter logic [WIDTH-1:0] KEEP_MASK = '0
) (
   // Clock and resets
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic power_on_rst,
   // Update strobes
   input wire logic set_en,
   input wire logic clear_en,
   input wire logic [WIDTH-1:0] wmask,
   // Contents
   output logic [WIDTH-1:0] value
);
   logic [WIDTH-1:0] next_value;

   always_comb begin
      next_value = value;
      if (set_en) begin
         next_value = value | wmask;
      end else if (clear_en) begin
         next_value = value & ~wmask;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (power_on_rst) begin
         value <= '0;
      end else if (rst) begin
         // Kept bits survive a host bus reset
         value <= next_value & KEEP_MASK;
      end else begin
         value <= next_value;
      end
   end
endmodule
